/* File: verilog/selfprog_seq_dev.sv */
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - erase on 000011 pattern plus store, page
// - erase ignores data and non-page pointer bits
// - load pattern plus store fills buffer word
// - buffer cleared after write, re-enable, reset
// - core never loads a word twice
// - eeprom write during loading discards buffer
// - write pattern plus store programs page
// - boot-section operations stall the core
// - pointer captured when operation starts
// - lock setting ignores the pointer
// - program read uses pointer bit zero
// - interrupt level while go bit clear
// - app section read-blocked, busy bit set
// - busy holds until re-enable command
// - lock pattern: zero data bits program locks
// - lock programming keeps flash readable, no stall
// - eeprom write blocks operations and fuse reads
// - pointer 1 plus lock read returns locks
// - go and select self-clear on completion/timeout
// - pointers 0,3,2 return fuse bytes
// - programmed bits read zero
// - core keeps interrupts off in timed sequence
// - operations last about 3.7 milliseconds
module selfprog_seq_dev #(
  parameter int OP_CYCLES = selfprog_pkg::OP_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // core side
  selfprog_if.dev sp,
  // flash array
  output logic o_fl_erase,
  output logic o_fl_wr_en,
  output logic [8:0] o_fl_page,
  output logic [5:0] o_fl_word_idx,
  output logic [15:0] o_fl_wdata,
  output logic [14:0] o_fl_raddr,
  input wire logic [15:0] i_fl_rdata,
  // lock and fuse bits
  output logic o_lock_wr,
  output logic [5:0] o_lock_wdata,
  input wire logic [5:0] i_lock_bits,
  input wire logic [7:0] i_fuse_low,
  input wire logic [7:0] i_fuse_high,
  input wire logic [2:0] i_fuse_ext
);
  localparam int PAGE_WORDS_L = selfprog_pkg::PAGE_WORDS;
  localparam logic [16:0] OP_LAST = 17'(OP_CYCLES - 1);
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE, OP_LOCK} op_e;
  op_e op_r;
  logic go_r;
  logic [3:0] mode_r;
  logic irq_en_r;
  logic busy_r;
  logic [2:0] win_r;
  logic [16:0] op_cnt_r;
  logic [6:0] stream_r;
  logic [15:0] buf_r [PAGE_WORDS_L];
  logic [63:0] valid_r;
  logic rd_pend_r;
  logic rd_hi_r;
  logic [5:0] cmd;
  logic spm_ok;
  logic lpm_fuse;
  logic do_load;
  logic do_erase;
  logic do_write;
  logic do_lock;
  logic do_reen;
  logic op_done;
  logic buf_clear;
  logic [8:0] ptr_page;
  logic [5:0] ptr_word;

  assign ptr_page = sp.ptr[selfprog_pkg::PAGE_LSB +: selfprog_pkg::PAGE_W];
  assign ptr_word = sp.ptr[selfprog_pkg::WORD_LSB +: selfprog_pkg::WORD_W];
  // rebuild the six-bit pattern: bit 5 zero, mode bits 4..1, go bit 0
  assign cmd = {1'b0, mode_r, go_r};
  // store accepted only while armed, idle, inside the window and eeprom quiet
  assign spm_ok = sp.spm && go_r && op_r == OP_IDLE && win_r < selfprog_pkg::SPM_WINDOW
                  && !sp.eeprom_write_busy;
  assign do_load = spm_ok && cmd == selfprog_pkg::CMD_LOAD;
  assign do_erase = spm_ok && cmd == selfprog_pkg::CMD_ERASE;
  assign do_write = spm_ok && cmd == selfprog_pkg::CMD_WRITE;
  assign do_lock = spm_ok && cmd == selfprog_pkg::CMD_LOCK;
  assign do_reen = spm_ok && cmd == selfprog_pkg::CMD_REENABLE;
  assign lpm_fuse = sp.lpm && go_r && mode_r[selfprog_pkg::LOCK_SEL_BIT - 1]
                    && op_r == OP_IDLE && win_r < selfprog_pkg::LPM_WINDOW;
  assign op_done = op_r != OP_IDLE && op_cnt_r == OP_LAST;
  // reset clear comes from the flops themselves
  assign buf_clear = (op_done && op_r == OP_WRITE) || do_reen
                     || (sp.eeprom_write_busy && valid_r != 64'h0);

  // control bits, timed window and self-clearing
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      go_r <= 1'b0;
      mode_r <= 4'h0;
      irq_en_r <= 1'b0;
      win_r <= 3'h0;
    end else begin
      if (sp.ctrl_wr) begin
        irq_en_r <= sp.ctrl_wdata[selfprog_pkg::IRQ_EN_BIT];
      end
      if (sp.ctrl_wr && !go_r && op_r == OP_IDLE && !sp.eeprom_write_busy) begin
        go_r <= sp.ctrl_wdata[selfprog_pkg::GO_BIT];
        mode_r <= sp.ctrl_wdata[4:1];
        win_r <= 3'h0;
      end else if (op_done) begin
        go_r <= 1'b0;
        mode_r <= 4'h0;
      end else if (go_r && op_r == OP_IDLE && !(do_erase || do_write || do_lock)) begin
        if (do_load || do_reen || lpm_fuse || spm_ok
            || win_r == selfprog_pkg::SPM_WINDOW - 3'h1) begin
          go_r <= 1'b0;
          mode_r <= 4'h0;
        end else begin
          win_r <= win_r + 3'h1;
        end
      end
    end
  end

  // operation sequencer timed by its cycle counter
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_r <= OP_IDLE;
      op_cnt_r <= 17'h0;
      o_fl_page <= 9'h0;
      sp.core_stall <= 1'b0;
    end else begin
      if (op_r == OP_IDLE) begin
        op_cnt_r <= 17'h0;
        if (do_erase || do_write) begin
          op_r <= do_erase ? OP_ERASE : OP_WRITE;
          o_fl_page <= ptr_page;
          sp.core_stall <= ptr_page >= selfprog_pkg::BOOT_FIRST_PAGE;
        end else if (do_lock) begin
          op_r <= OP_LOCK;
        end
      end else if (op_done) begin
        op_r <= OP_IDLE;
        sp.core_stall <= 1'b0;
      end else begin
        op_cnt_r <= op_cnt_r + 17'h1;
      end
    end
  end

  // busy flag for the readable application section
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_r <= 1'b0;
    end else if (do_erase || do_write) begin
      busy_r <= 1'b1;
    end else if (do_reen) begin
      busy_r <= 1'b0;
    end
  end

  // temporary page buffer, one word per flop group
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_WORDS_L; gi++) begin : g_buf
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          buf_r[gi] <= 16'hFFFF;
          valid_r[gi] <= 1'b0;
        end else if (buf_clear) begin
          buf_r[gi] <= 16'hFFFF;
          valid_r[gi] <= 1'b0;
        end else if (do_load && ptr_word == 6'(gi)) begin
          buf_r[gi] <= sp.data;
          valid_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // array strobes: erase pulse, word stream at write start, lock pulse
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fl_erase <= 1'b0;
      o_fl_wr_en <= 1'b0;
      o_fl_word_idx <= 6'h0;
      o_fl_wdata <= 16'hFFFF;
      o_lock_wr <= 1'b0;
      o_lock_wdata <= 6'h3F;
      stream_r <= 7'h0;
    end else begin
      o_fl_erase <= do_erase;
      o_lock_wr <= do_lock;
      if (do_lock) begin
        o_lock_wdata <= sp.data[5:0];
      end
      // streaming finishes long before the op counter, so the buffer is still intact
      if (do_write) begin
        stream_r <= 7'h40;
      end else if (stream_r != 7'h0) begin
        stream_r <= stream_r - 7'h1;
      end
      o_fl_wr_en <= stream_r != 7'h0;
      o_fl_word_idx <= 6'(7'h40 - stream_r);
      o_fl_wdata <= buf_r[6'(7'h40 - stream_r)];
    end
  end

  // program reads: fuse/lock bytes at once, flash bytes one cycle later
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp.lpm_data <= 8'h00;
      sp.lpm_valid <= 1'b0;
      o_fl_raddr <= 15'h0;
      rd_pend_r <= 1'b0;
      rd_hi_r <= 1'b0;
    end else begin
      sp.lpm_valid <= 1'b0;
      rd_pend_r <= 1'b0;
      if (rd_pend_r) begin
        sp.lpm_data <= rd_hi_r ? i_fl_rdata[15:8] : i_fl_rdata[7:0];
        sp.lpm_valid <= 1'b1;
      end else if (lpm_fuse) begin
        sp.lpm_valid <= 1'b1;
        if (sp.eeprom_write_busy) begin
          sp.lpm_data <= selfprog_pkg::BLOCKED_BYTE;
        end else if (sp.ptr == selfprog_pkg::PTR_LOCK) begin
          sp.lpm_data <= {2'b11, i_lock_bits};
        end else if (sp.ptr == selfprog_pkg::PTR_FUSE_LOW) begin
          sp.lpm_data <= i_fuse_low;
        end else if (sp.ptr == selfprog_pkg::PTR_FUSE_HIGH) begin
          sp.lpm_data <= i_fuse_high;
        end else if (sp.ptr == selfprog_pkg::PTR_FUSE_EXT) begin
          sp.lpm_data <= {5'h1F, i_fuse_ext};
        end else begin
          sp.lpm_data <= selfprog_pkg::BLOCKED_BYTE;
        end
      end else if (sp.lpm) begin
        if (busy_r && ptr_page < selfprog_pkg::BOOT_FIRST_PAGE) begin
          sp.lpm_data <= selfprog_pkg::BLOCKED_BYTE;
          sp.lpm_valid <= 1'b1;
        end else begin
          o_fl_raddr <= sp.ptr[15:1];
          rd_hi_r <= sp.ptr[0];
          rd_pend_r <= 1'b1;
        end
      end
    end
  end

  // status readback and level interrupt
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp.ctrl_rdata <= 8'h00;
      sp.irq <= 1'b0;
    end else begin
      sp.ctrl_rdata <= {irq_en_r, busy_r, 1'b0, mode_r, go_r};
      sp.irq <= irq_en_r & ~go_r;
    end
  end
endmodule

/* File: verilog/selfprog_pkg.sv */
package selfprog_pkg;
  // control/status byte field positions
  localparam int GO_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int LOCK_SEL_BIT = 3;
  localparam int REENABLE_BIT = 4;
  localparam int BUSY_BIT = 6;
  localparam int IRQ_EN_BIT = 7;
  // command patterns, bits 5..0 (bit 7 is the interrupt enable)
  localparam logic [5:0] CMD_LOAD = 6'h01;
  localparam logic [5:0] CMD_ERASE = 6'h03;
  localparam logic [5:0] CMD_WRITE = 6'h05;
  localparam logic [5:0] CMD_LOCK = 6'h09;
  localparam logic [5:0] CMD_REENABLE = 6'h11;
  // pointer layout: bit 0 byte select, 6..1 word in page, 15..7 page index
  localparam int WORD_LSB = 1;
  localparam int WORD_W = 6;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_W = 9;
  localparam int PAGE_WORDS = 64;
  localparam logic [8:0] BOOT_FIRST_PAGE = 9'h1C0;
  // fuse and lock read pointers
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  // timed sequence windows in cycles
  localparam logic [2:0] SPM_WINDOW = 3'h4;
  localparam logic [2:0] LPM_WINDOW = 3'h3;
  // operation time
  localparam int CLK_PERIOD_NS = 50;
  localparam int OP_MIN_TIME_NS = 3700000;
  localparam int OP_CYCLES = (OP_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // controller register offsets and bits
  localparam logic [7:0] REG_PTR = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CMD_SPM_BIT = 8;
  localparam int CMD_LPM_BIT = 9;
  localparam int ST_DUP_BIT = 18;
  localparam logic [7:0] BLOCKED_BYTE = 8'hFF;
endpackage

/* File: verilog/selfprog_if.sv */
`timescale 1ns/1ps
interface selfprog_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic spm;
  logic lpm;
  logic [15:0] ptr;
  logic [15:0] data;
  logic eeprom_write_busy;
  logic [7:0] ctrl_rdata;
  logic [7:0] lpm_data;
  logic lpm_valid;
  logic core_stall;
  logic irq;

  modport core (
    output ctrl_wr, ctrl_wdata, spm, lpm, ptr, data, eeprom_write_busy,
    input ctrl_rdata, lpm_data, lpm_valid, core_stall, irq
  );
  modport dev (
    input ctrl_wr, ctrl_wdata, spm, lpm, ptr, data, eeprom_write_busy,
    output ctrl_rdata, lpm_data, lpm_valid, core_stall, irq
  );
endinterface

/* File: verilog/selfprog_ctrl_host.sv */
`timescale 1ns/1ps
module selfprog_ctrl_host (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // eeprom status
  input wire logic i_eeprom_write_busy,
  // link to the sequencer
  selfprog_if.core sp
);
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CTRL, SEQ_STROBE} seq_e;
  seq_e seq_r;
  logic [9:0] cmd_r;
  logic [7:0] lpm_byte_r;
  logic dup_err_r;
  logic [63:0] loaded_r;
  logic wr_acc;
  logic rd_acc;
  logic cmd_go;
  logic is_load;
  logic dup_hit;
  logic [5:0] word_idx;

  assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;
  assign rd_acc = i_psel & ~i_penable & ~i_pwrite;
  assign word_idx = sp.ptr[selfprog_pkg::WORD_LSB +: selfprog_pkg::WORD_W];
  assign cmd_go = wr_acc && (i_paddr == selfprog_pkg::REG_CMD) && (seq_r == SEQ_IDLE);
  assign is_load = (i_pwdata[5:0] == selfprog_pkg::CMD_LOAD) && i_pwdata[selfprog_pkg::CMD_SPM_BIT];
  assign dup_hit = cmd_go && is_load && loaded_r[word_idx];

  // pready is set from the setup phase, so no wait state, and read data comes from a flop
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= i_psel & ~i_penable & ~o_pready;
      o_pslverr <= 1'b0;
      if (rd_acc) begin
        if (i_paddr == selfprog_pkg::REG_PTR) begin
          o_prdata <= {16'h0000, sp.ptr};
        end else if (i_paddr == selfprog_pkg::REG_DATA) begin
          o_prdata <= {16'h0000, sp.data};
        end else if (i_paddr == selfprog_pkg::REG_CMD) begin
          o_prdata <= {22'h0, cmd_r};
        end else if (i_paddr == selfprog_pkg::REG_STATUS) begin
          // bit 17 stays zero between the dup flag and the sequence-busy bit
          o_prdata <= {11'h000, sp.core_stall, sp.irq, dup_err_r, 1'b0, (seq_r != SEQ_IDLE),
                       lpm_byte_r, sp.ctrl_rdata};
        end else begin
          o_prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // pointer and data words seen by the sequencer
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp.ptr <= 16'h0000;
      sp.data <= 16'h0000;
    end else if (wr_acc && i_paddr == selfprog_pkg::REG_PTR) begin
      sp.ptr <= i_pwdata[15:0];
    end else if (wr_acc && i_paddr == selfprog_pkg::REG_DATA) begin
      sp.data <= i_pwdata[15:0];
    end
  end

  // control write and strobe go out back to back, so no interrupt can split them
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_r <= SEQ_IDLE;
      cmd_r <= 10'h000;
      sp.ctrl_wr <= 1'b0;
      sp.ctrl_wdata <= 8'h00;
      sp.spm <= 1'b0;
      sp.lpm <= 1'b0;
    end else begin
      sp.ctrl_wr <= 1'b0;
      sp.spm <= 1'b0;
      sp.lpm <= 1'b0;
      case (seq_r)
        SEQ_IDLE: begin
          if (cmd_go && !dup_hit) begin
            cmd_r <= i_pwdata[9:0];
            sp.ctrl_wdata <= i_pwdata[7:0];
            sp.ctrl_wr <= 1'b1;
            seq_r <= SEQ_CTRL;
          end
        end
        SEQ_CTRL: begin
          sp.spm <= cmd_r[selfprog_pkg::CMD_SPM_BIT];
          sp.lpm <= cmd_r[selfprog_pkg::CMD_LPM_BIT];
          seq_r <= SEQ_STROBE;
        end
        default: begin
          seq_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // words loaded since the last write or re-enable command; a second load is refused
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loaded_r <= 64'h0;
      dup_err_r <= 1'b0;
    end else begin
      if (dup_hit) begin
        dup_err_r <= 1'b1;
      end else if (wr_acc && i_paddr == selfprog_pkg::REG_STATUS
                   && i_pwdata[selfprog_pkg::ST_DUP_BIT]) begin
        dup_err_r <= 1'b0;
      end
      if (cmd_go && !dup_hit && is_load) begin
        loaded_r[word_idx] <= 1'b1;
      end else if (cmd_go && i_pwdata[selfprog_pkg::CMD_SPM_BIT]
                   && (i_pwdata[5:0] == selfprog_pkg::CMD_WRITE
                       || i_pwdata[5:0] == selfprog_pkg::CMD_REENABLE)) begin
        loaded_r <= 64'h0;
      end
    end
  end

  // last program-read byte and eeprom busy forwarded
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lpm_byte_r <= 8'h00;
      sp.eeprom_write_busy <= 1'b0;
    end else begin
      sp.eeprom_write_busy <= i_eeprom_write_busy;
      if (sp.lpm_valid) begin
        lpm_byte_r <= sp.lpm_data;
      end
    end
  end
endmodule

/* File: sim/selfprog_link_sva.sv */
`timescale 1ns/1ps
// watches the core-to-sequencer link; go and busy are read back through ctrl_rdata
module selfprog_link_sva (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // link signals
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic spm,
  input wire logic lpm,
  input wire logic [15:0] ptr,
  input wire logic [15:0] data,
  input wire logic eeprom_write_busy,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [7:0] lpm_data,
  input wire logic lpm_valid,
  input wire logic core_stall,
  input wire logic irq
);
  localparam int OP_MAX = 300;
  logic wr_seen_r;
  logic [7:0] wr_byte_r;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // shorthand views of the control byte; read back lags the device's own bits by a cycle
  wire logic go = ctrl_rdata[selfprog_pkg::GO_BIT];
  wire logic busy = ctrl_rdata[selfprog_pkg::BUSY_BIT];
  wire logic irq_want = ctrl_rdata[selfprog_pkg::IRQ_EN_BIT] & ~go;
  wire logic [5:0] arm_cmd = wr_byte_r[5:0];
  wire logic op_go = spm & wr_seen_r & ~eeprom_write_busy
                     & ((arm_cmd == selfprog_pkg::CMD_ERASE)
                        | (arm_cmd == selfprog_pkg::CMD_WRITE));
  // control write the device can take; the read-back go bit is too late to arm on
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_seen_r <= 1'b0;
      wr_byte_r <= 8'h00;
    end else begin
      wr_seen_r <= ctrl_wr & ~eeprom_write_busy & ~go;
      wr_byte_r <= ctrl_wdata;
    end
  end
  // compared only once the cause has settled, so either flop stage passes
  irq_level_a: assert property ($past(i_rst_n) && $stable(irq_want) |-> irq == irq_want)
    else $error("irq does not follow enable and go");
  go_timeout_a: assert property ((!spm && !lpm)[*2] ##0 $rose(go) ##1 (!spm && !lpm)[*4]
    |=> !go) else $error("go did not clear after unanswered window");
  load_done_a: assert property (spm && wr_seen_r && arm_cmd == selfprog_pkg::CMD_LOAD
    && !eeprom_write_busy |-> ##1 go ##1 !go) else $error("go stuck after buffer load");
  op_busy_a: assert property (op_go |-> ##[1:3] busy)
    else $error("busy not set by erase or write");
  op_length_a: assert property (op_go |=> go[*8] ##[1:OP_MAX] !go)
    else $error("operation length wrong or go never cleared");
  busy_hold_a: assert property (busy && !spm && !$past(spm) |=> busy)
    else $error("busy dropped without re-enable");
  lock_nostall_a: assert property (go && ctrl_rdata[3] |-> !core_stall)
    else $error("core stalled during lock access");
  stall_busy_a: assert property (core_stall |-> ##[0:1] busy)
    else $error("core stalled outside an erase or write");
  ee_block_a: assert property (ctrl_wr && eeprom_write_busy && !go |=> (!go)[*2])
    else $error("go armed while eeprom busy");
  lpm_answer_a: assert property (lpm |-> ##[1:2] lpm_valid)
    else $error("program read not answered");
endmodule

/* File: sim/flash_self_programming_ctrl_bench.sv */
`timescale 1ns/1ps
module flash_self_programming_ctrl_bench;
  // clock, reset, apb master
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ee_busy = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, fl_erase, fl_wr_en, lock_wr;
  // flash array and fuse store stand-ins
  logic [8:0] fl_page, pg;
  logic [5:0] fl_word, lock_wdata, lockw;
  logic [15:0] fl_wdata, fl_rdata;
  logic [14:0] fl_raddr;
  logic [5:0] lock_bits = 6'h2D;
  logic [7:0] fuse_low = 8'h62, fuse_high = 8'h99, e;
  logic [2:0] fuse_ext = 3'h5;
  logic [15:0] wbuf [64];
  int wcnt, fail_count, tests_run;
  selfprog_if link();
  // flash words are a fixed scramble of their address
  assign fl_rdata = {fl_raddr, 1'b0} ^ 16'h5A3C;
  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  selfprog_ctrl_host u_selfprog_ctrl_host (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_eeprom_write_busy(ee_busy), .sp(link));
  selfprog_seq_dev #(.OP_CYCLES(200)) u_selfprog_seq_dev (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .sp(link), .o_fl_erase(fl_erase), .o_fl_wr_en(fl_wr_en),
    .o_fl_page(fl_page), .o_fl_word_idx(fl_word), .o_fl_wdata(fl_wdata),
    .o_fl_raddr(fl_raddr), .i_fl_rdata(fl_rdata), .o_lock_wr(lock_wr),
    .o_lock_wdata(lock_wdata), .i_lock_bits(lock_bits), .i_fuse_low(fuse_low),
    .i_fuse_high(fuse_high), .i_fuse_ext(fuse_ext));
  selfprog_link_sva u_selfprog_link_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata), .spm(link.spm), .lpm(link.lpm),
    .ptr(link.ptr), .data(link.data), .eeprom_write_busy(link.eeprom_write_busy),
    .ctrl_rdata(link.ctrl_rdata), .lpm_data(link.lpm_data), .lpm_valid(link.lpm_valid),
    .core_stall(link.core_stall), .irq(link.irq));
  // record what the sequencer hands the array
  always @(posedge i_ref_clk) begin
    if (fl_wr_en === 1'b1) begin
      wbuf[fl_word] <= fl_wdata;
      wcnt <= wcnt + 1;
    end
    if (fl_erase === 1'b1 || fl_wr_en === 1'b1) pg <= fl_page;
    if (lock_wr === 1'b1) lockw <= lock_wdata;
  end
  // one apb transfer; an idle cycle before setup keeps psel single-driven per step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    // pready is a flop: read at the edge before it updates, so this is the sampled value
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rdv = prdata;
    chk("pslverr", 32'h0, 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task cmd(input logic [7:0] b, input logic s, input logic l);
    apb(1'b1, selfprog_pkg::REG_CMD, {22'h0, l, s, b});
  endtask
  // poll until neither the sequence nor go is pending
  task idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
      n++;
    end while ((rdv[16] | rdv[0]) !== 1'b0 && n < 150);
    if (n >= 150) fail_count++;
  endtask
  task setp(input logic [15:0] p, input logic [15:0] d);
    apb(1'b1, selfprog_pkg::REG_PTR, {16'h0, p});
    apb(1'b1, selfprog_pkg::REG_DATA, {16'h0, d});
  endtask
  task op(input logic [15:0] p, input logic [15:0] d, input logic [7:0] b);
    setp(p, d);
    cmd(b, 1'b1, 1'b0);
  endtask
  // normal read through lpm; result lands in rdv[15:8]
  task pread(input logic [15:0] p);
    setp(p, 16'h0000);
    cmd(8'h00, 1'b0, 1'b1);
    idle();
  endtask
  function automatic logic [15:0] pp(input logic [8:0] page, input logic [5:0] w);
    return {page, w, 1'b0};
  endfunction
  function automatic logic [7:0] fb(input logic [15:0] p);
    logic [15:0] w;
    w = {p[15:1], 1'b0} ^ 16'h5A3C;
    return p[0] ? w[15:8] : w[7:0];
  endfunction
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog sized well above the sequence below
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    wcnt = 0;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("status reset", 32'h0, rdv);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rdv);
    // fuse and lock bytes, read back as stored (0 = programmed)
    for (int i = 0; i < 4; i++) begin
      setp(16'(i), 16'hFFFF);
      cmd(8'h09, 1'b0, 1'b1);
      idle();
      case (i)
        0: e = fuse_low;
        1: e = {2'b11, lock_bits};
        2: e = {5'h1F, fuse_ext};
        default: e = fuse_high;
      endcase
      chk("fuse byte", {24'h0, e}, {24'h0, rdv[15:8]});
      chk("go after read", 32'h0, 32'(rdv[3:0]));
    end
    // armed but never answered
    cmd(8'h09, 1'b0, 1'b0);
    repeat (8) @(posedge i_ref_clk);
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("window timeout", 32'h0, 32'(rdv[3:0]));
    // load three words, then write with the pointer changed right after start
    op(pp(9'h012, 6'd0), 16'h1234, 8'h01);
    op(pp(9'h012, 6'd5), 16'hBEEF, 8'h01);
    op(pp(9'h012, 6'd63), 16'h0F0F, 8'h01);
    idle();
    wcnt = 0;
    op(pp(9'h012, 6'd0), 16'hAAAA, 8'h05);
    apb(1'b1, selfprog_pkg::REG_PTR, 32'h0000FFFE);
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("busy set", 32'h1, 32'(rdv[6]));
    chk("app no stall", 32'h0, 32'(rdv[20]));
    idle();
    chk("page words", 32'd64, 32'(wcnt));
    chk("write page", 32'h012, 32'(pg));
    chk("word 0", 32'h1234, 32'(wbuf[0]));
    chk("word 5", 32'hBEEF, 32'(wbuf[5]));
    chk("word 63", 32'h0F0F, 32'(wbuf[63]));
    chk("word 1", 32'hFFFF, 32'(wbuf[1]));
    pread(16'h0A03);
    chk("blocked read", 32'hFF, 32'(rdv[15:8]));
    chk("busy holds", 32'h1, 32'(rdv[6]));
    op(16'h0000, 16'h0000, 8'h11);
    idle();
    chk("busy cleared", 32'h0, 32'(rdv[6]));
    pread(16'h0A03);
    chk("high byte", 32'(fb(16'h0A03)), 32'(rdv[15:8]));
    pread(16'h0A02);
    chk("low byte", 32'(fb(16'h0A02)), 32'(rdv[15:8]));
    // load, clear by re-enable, then write: both old and new words gone
    op(pp(9'h012, 6'd7), 16'h5555, 8'h01);
    idle();
    op(16'h0000, 16'h0000, 8'h11);
    idle();
    op(pp(9'h012, 6'd0), 16'h0000, 8'h05);
    idle();
    chk("cleared by write", 32'hFFFF, 32'(wbuf[0]));
    chk("cleared by reenable", 32'hFFFF, 32'(wbuf[7]));
    op(16'h0000, 16'h0000, 8'h11);
    idle();
    // boot page erase with junk in data and low pointer bits
    op(16'hE2FF, 16'h1357, 8'h03);
    repeat (2) @(posedge i_ref_clk);
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("boot stall", 32'h1, 32'(rdv[20]));
    idle();
    chk("erase page", 32'h1C5, 32'(pg));
    op(16'h0000, 16'h0000, 8'h11);
    idle();
    // lock setting ignores the pointer and leaves flash readable
    op(16'hBEEF, 16'h00F5, 8'h09);
    repeat (2) @(posedge i_ref_clk);
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("lock no stall", 32'h0, 32'({rdv[20], rdv[6]}));
    idle();
    chk("lock data", 32'h35, 32'(lockw));
    // second load of one word is refused and flagged
    op(pp(9'h012, 6'd2), 16'h1111, 8'h01);
    idle();
    op(pp(9'h012, 6'd2), 16'h2222, 8'h01);
    idle();
    chk("dup flag", 32'h1, 32'(rdv[18]));
    apb(1'b1, selfprog_pkg::REG_STATUS, 32'h00040000);
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("dup clear", 32'h0, 32'(rdv[18]));
    op(pp(9'h012, 6'd0), 16'h0000, 8'h05);
    idle();
    chk("dup refused", 32'h1111, 32'(wbuf[2]));
    // eeprom write mid-load discards the buffer and blocks commands
    op(pp(9'h012, 6'd3), 16'h7777, 8'h01);
    idle();
    ee_busy <= 1'b1;
    op(pp(9'h012, 6'd4), 16'h8888, 8'h01);
    // one idle edge so the read lands while an armed go would still show
    @(posedge i_ref_clk);
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("go blocked", 32'h0, 32'(rdv[0]));
    ee_busy <= 1'b0;
    op(pp(9'h012, 6'd0), 16'h0000, 8'h05);
    idle();
    chk("discarded", 32'hFFFF, 32'(wbuf[3]));
    chk("ignored load", 32'hFFFF, 32'(wbuf[4]));
    op(16'h0000, 16'h0000, 8'h11);
    idle();
    // interrupt level follows enable while go is clear
    cmd(8'h80, 1'b0, 1'b0);
    repeat (3) @(posedge i_ref_clk);
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("irq on", 32'h1, 32'(rdv[19]));
    cmd(8'h00, 1'b0, 1'b0);
    repeat (3) @(posedge i_ref_clk);
    apb(1'b0, selfprog_pkg::REG_STATUS, 32'h0);
    chk("irq off", 32'h0, 32'(rdv[19]));
    wrap_up();
  end
endmodule
